// ### common/gpx_pkg.sv
/*
 * Constants and carrier types for the shared process byte exchange block.
 * Assumes byte-wide register access and a token bus layer that delivers
 * already deframed change entries and reports lost stations.
 */
package gpx_pkg;

    // station list
    localparam int STATIONS = 32;
    localparam int ST_IDX_W = 5;
    localparam int ST_FLAG_W = 3;
    localparam int ST_FAIL_BIT = 0;
    localparam int ST_RXOVF_BIT = 1;
    localparam int ST_TXOVF_BIT = 2;

    // job numbers written to the job register
    localparam logic [7:0] JOB_SEND = 8'hd2;
    localparam logic [7:0] JOB_RECV = 8'hd3;
    localparam logic [7:0] JOB_LIST = 8'hc9;

    // register offsets
    localparam logic [7:0] ADDR_OUT_BASE = 8'h00;
    localparam logic [7:0] ADDR_IN_BASE = 8'h10;
    localparam logic [7:0] ADDR_SLOT_OBJ = 8'h18;
    localparam logic [7:0] ADDR_SLOT_STN = 8'h20;
    localparam logic [7:0] ADDR_LIST_BASE = 8'h40;
    localparam logic [7:0] ADDR_CTRL = 8'h60;
    localparam logic [7:0] ADDR_JOB = 8'h61;
    localparam logic [7:0] ADDR_JOB_STAT = 8'h62;
    localparam logic [7:0] ADDR_OUT_OBJ = 8'h63;

    // field positions
    localparam int CTRL_SYNC_BIT = 0;
    localparam int CTRL_RUN_BIT = 1;
    localparam int SLOT_EN_BIT = 7;
    localparam int JS_DONE_BIT = 0;
    localparam int JS_GROUP_BIT = 2;
    localparam int JS_BADJOB_BIT = 3;

    // values after reset
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [3:0] JS_RESET = 4'h0;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bus_req_type;

    typedef struct packed {
        logic [ST_IDX_W-1:0] station;
        logic [7:0]          obj;
        logic [7:0]          data;
    } rx_entry_type;

    typedef struct packed {
        logic [7:0] obj;
        logic [7:0] data;
        logic       last;
    } tx_entry_type;

endpackage

// ### hw/gpx_change_detect.sv
/*
 * Snapshot of the shared output bytes and new/old comparison.
 * Capture may stay high for many cycles (free mode idle); changed is combinational.
 */
`timescale 1ns/1ps
module gpx_change_detect
    import gpx_pkg::*;
#(
    parameter int N = 16
) (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    // comparison
    input  wire logic                capture,
    input  wire logic [N-1:0][7:0]   cur,
    output logic      [N-1:0]        changed,
    output logic      [N-1:0][7:0]   snap
);

    logic [N-1:0][7:0] snap_q;

    // RQ8 - value at comparison only
    for (genvar g = 0; g < N; g++) begin : g_cmp
        assign changed[g] = cur[g] != snap_q[g];
    end

    // RQ25 - snapshot update
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            snap_q <= '0;
        end else if (capture) begin
            snap_q <= cur;
        end
    end

    assign snap = snap_q;

endmodule

// ### hw/gpx_exchange.sv
/*
 * Change-driven exchange of shared process bytes over a token bus.
 * Assumes the bus layer broadcasts tx entries at high priority, delivers
 * received entries without back-pressure, and pulses stn_lost on loss.
 */
// Local design decisions: the plain strobed port and the address map.
// Notes on behaviour
// RQ1 - free mode: received byte goes to input area at once, per-byte consistent
// RQ2 - free mode: no receive overflow detection at all
// RQ3 - only bytes changed at the sender ever appear in frames
// RQ4 - repeated receptions keep only the newest value in the slot
// RQ5 - cycle-synchronized: outputs captured only at the send checkpoint
// RQ6 - each checkpoint compares every output byte, sends only differing ones
// RQ7 - host marks send checkpoint with job 210
// RQ8 - toggled byte back at old value by comparison is not sent
// RQ9 - job 211 moves all changed inputs into the input area, then host reads
// RQ10 - repeated change before receive checkpoint keeps newest, logs overflow
// RQ11 - host should space checkpoint calls more than 50 ms apart
// RQ12 - host sets source type NN and status word; other parameters ignored
// RQ13 - host synchronizes each interface in restart routines first
// RQ14 - host may poll control call until input image error clears
// RQ15 - host sends at cycle start and receives at cycle end
// RQ16 - host stop zeroes outputs; formerly non-zero bytes broadcast as zero
// RQ17 - station failure readable by host through station list job 201
// RQ18 - any processing error shows as group error in job status
// RQ19 - cycle-synchronized: unsent changes at next checkpoint log overflow
// RQ20 - failure of any sending station recorded in station list
// RQ21 - failed station's input bytes cleared to zero
// RQ22 - station list holds 32 status bytes, one per station
// RQ23 - changed bytes packed with object ids into broadcast change frame
// RQ24 - free mode: device picks comparison time after previous frame
// RQ25 - snapshot of each output byte updated at every comparison
`timescale 1ns/1ps
module gpx_exchange
    import gpx_pkg::*;
#(
    parameter int                N_OUT       = 16,
    parameter int                N_IN        = 8,
    parameter logic [ST_IDX_W-1:0] OWN_STATION = 5'h00
) (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    // register port
    input  wire bus_req_type         bus_req,
    output logic      [7:0]          rd_data,
    // change frames out
    output tx_entry_type             tx_entry,
    output logic                     tx_valid,
    output logic                     tx_high_prio,
    input  wire logic                tx_ready,
    // change frames in
    input  wire logic                rx_valid,
    input  wire rx_entry_type        rx_entry,
    // station supervision
    input  wire logic                stn_lost,
    input  wire logic [ST_IDX_W-1:0] stn_lost_idx
);

    localparam int OW = $clog2(N_OUT);
    localparam int IW = $clog2(N_IN);

    if (N_OUT < 2 || N_OUT > 16 || N_IN < 2 || N_IN > 8) begin : g_chk
        $error("gpx_exchange: N_OUT must be 2..16 and N_IN 2..8");
    end

    function automatic logic in_win(input logic [7:0] a, input logic [7:0] base, input int n);
        return (a >= base) && (int'(a) < int'(base) + n);
    endfunction

    function automatic logic [OW-1:0] first_set(input logic [N_OUT-1:0] m);
        first_set = '0;
        for (int i = N_OUT - 1; i >= 0; i--) begin
            if (m[i]) begin
                first_set = OW'(i);
            end
        end
    endfunction

    // registers
    logic [7:0]              ctrl_q;
    logic [7:0]              job_q;
    logic [3:0]              js_q;
    logic [7:0]              out_obj_q;
    logic [7:0]              rd_data_q;
    logic [N_OUT-1:0][7:0]   out_img_q;
    logic [N_IN-1:0][7:0]    in_img_q;
    logic [N_IN-1:0][7:0]    slot_obj_q;
    logic [N_IN-1:0][7:0]    slot_stn_q;
    // exchange state
    logic [N_IN-1:0][7:0]    pend_val_q;
    logic [N_IN-1:0]         pend_vld_q;
    logic [N_OUT-1:0][7:0]   tx_val_q;
    logic [N_OUT-1:0]        tx_pend_q;
    tx_entry_type            tx_q;
    logic                    tx_valid_q;
    logic                    tx_prio_q;
    // combinational
    logic                    sync_mode;
    logic                    host_run;
    logic [7:0]              off;
    logic                    job_wr;
    logic                    job_send;
    logic                    job_recv;
    logic                    job_list;
    logic                    cmp_go;
    logic [N_OUT-1:0][7:0]   eff;
    logic [N_OUT-1:0]        chg;
    logic [N_OUT-1:0][7:0]   snap;
    logic [N_IN-1:0]         hit;
    logic [N_IN-1:0]         lost_hit;
    logic                    emit;
    logic [OW-1:0]           emit_idx;
    logic                    set_rxovf;
    logic                    set_txovf;
    logic [7:0]              list_byte;
    logic                    group_err;
    logic [7:0]              rd_val;

    assign sync_mode = ctrl_q[CTRL_SYNC_BIT];
    assign host_run  = ctrl_q[CTRL_RUN_BIT];
    assign off       = bus_req.addr;
    assign job_wr    = bus_req.wr && bus_req.addr == ADDR_JOB;
    assign job_send  = job_wr && bus_req.wdata == JOB_SEND && sync_mode;
    assign job_recv  = job_wr && bus_req.wdata == JOB_RECV && sync_mode;
    assign job_list  = job_wr && bus_req.wdata == JOB_LIST;

    // RQ16 - stopped host reads as zero
    for (genvar g = 0; g < N_OUT; g++) begin : g_eff
        assign eff[g] = host_run ? out_img_q[g] : BYTE_RESET;
    end

    // RQ24 - free mode compares once the previous frame has left
    // RQ5 - cycle-synchronized compares only on the send job
    assign cmp_go = sync_mode ? job_send : (tx_pend_q == '0 && !tx_valid_q);

    gpx_change_detect #(
        .N       (N_OUT)
    ) u_detect (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .capture (cmp_go),
        .cur     (eff),
        .changed (chg),
        .snap    (snap)
    );

    for (genvar g = 0; g < N_IN; g++) begin : g_match
        assign hit[g] = rx_valid && slot_stn_q[g][SLOT_EN_BIT]
                        && slot_stn_q[g][ST_IDX_W-1:0] == rx_entry.station
                        && slot_obj_q[g] == rx_entry.obj;
        assign lost_hit[g] = stn_lost && slot_stn_q[g][SLOT_EN_BIT]
                             && slot_stn_q[g][ST_IDX_W-1:0] == stn_lost_idx;
    end

    // RQ10 - second change before the receive job
    // RQ2 - nothing flagged in free mode
    assign set_rxovf = sync_mode && !job_recv && |(hit & pend_vld_q);
    // RQ19 - changes still unsent at the next send job
    assign set_txovf = job_send && tx_pend_q != '0;

    gpx_station_list u_list (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .set_fail  (stn_lost),
        .fail_idx  (stn_lost_idx),
        .seen      (rx_valid),
        .seen_idx  (rx_entry.station),
        .set_rxovf (set_rxovf),
        .rxovf_idx (rx_entry.station),
        .set_txovf (set_txovf),
        .txovf_idx (OWN_STATION),
        .clr_ovf   (job_list),
        .rd_idx    (ST_IDX_W'(off - ADDR_LIST_BASE)),
        .rd_byte   (list_byte),
        .any_err   (group_err)
    );

    // register writes
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q     <= CTRL_RESET;
            job_q      <= BYTE_RESET;
            out_obj_q  <= BYTE_RESET;
            out_img_q  <= '0;
            slot_obj_q <= '0;
            slot_stn_q <= '0;
        end else if (bus_req.wr) begin
            if (bus_req.addr == ADDR_CTRL) begin
                ctrl_q <= bus_req.wdata;
            end
            if (job_wr) begin
                job_q <= bus_req.wdata;
            end
            if (bus_req.addr == ADDR_OUT_OBJ) begin
                out_obj_q <= bus_req.wdata;
            end
            if (in_win(off, ADDR_OUT_BASE, N_OUT)) begin
                out_img_q[OW'(off - ADDR_OUT_BASE)] <= bus_req.wdata;
            end
            if (in_win(off, ADDR_SLOT_OBJ, N_IN)) begin
                slot_obj_q[IW'(off - ADDR_SLOT_OBJ)] <= bus_req.wdata;
            end
            if (in_win(off, ADDR_SLOT_STN, N_IN)) begin
                slot_stn_q[IW'(off - ADDR_SLOT_STN)] <= bus_req.wdata;
            end
        end
    end

    // job status: done and unknown job; group error read live
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            js_q <= JS_RESET;
        end else if (job_wr) begin
            js_q[JS_DONE_BIT]   <= 1'b1;
            js_q[JS_BADJOB_BIT] <= !(bus_req.wdata == JOB_SEND || bus_req.wdata == JOB_RECV
                                     || bus_req.wdata == JOB_LIST);
        end
    end

    // receive side, one block per slot, all slots updated in parallel
    for (genvar g = 0; g < N_IN; g++) begin : g_rx
        always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
                in_img_q[g]   <= BYTE_RESET;
                pend_val_q[g] <= BYTE_RESET;
                pend_vld_q[g] <= 1'b0;
            end else if (lost_hit[g]) begin
                // RQ21 - clear inputs of a failed sender
                in_img_q[g]   <= BYTE_RESET;
                pend_vld_q[g] <= 1'b0;
            end else begin
                // RQ9 - receive job commits pending bytes
                if (job_recv && pend_vld_q[g]) begin
                    in_img_q[g]   <= pend_val_q[g];
                    pend_vld_q[g] <= 1'b0;
                end
                if (hit[g]) begin
                    // RQ1 - free mode writes straight through
                    // RQ4 - newest value overwrites
                    if (!sync_mode) begin
                        in_img_q[g] <= rx_entry.data;
                    end else begin
                        pend_val_q[g] <= rx_entry.data;
                        pend_vld_q[g] <= 1'b1;
                    end
                end
            end
        end
    end

    // transmit side
    assign emit     = tx_pend_q != '0 && (!tx_valid_q || tx_ready);
    assign emit_idx = first_set(tx_pend_q);

    // RQ6 - only differing bytes become pending
    // RQ3 - unchanged bytes never enter the frame
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_pend_q <= '0;
            tx_val_q  <= '0;
        end else begin
            if (emit) begin
                tx_pend_q[emit_idx] <= 1'b0;
            end
            if (cmp_go) begin
                for (int i = 0; i < N_OUT; i++) begin
                    if (chg[i]) begin
                        tx_pend_q[i] <= 1'b1;
                        tx_val_q[i]  <= eff[i];
                    end
                end
            end
        end
    end

    // RQ23 - entries carry object id, broadcast at high priority
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_q       <= '0;
            tx_valid_q <= 1'b0;
            tx_prio_q  <= 1'b0;
        end else begin
            tx_prio_q <= 1'b1;
            if (emit) begin
                tx_q.obj   <= out_obj_q + 8'(emit_idx);
                tx_q.data  <= tx_val_q[emit_idx];
                tx_q.last  <= (tx_pend_q & ~(N_OUT'(1) << emit_idx)) == '0;
                tx_valid_q <= 1'b1;
            end else if (tx_ready) begin
                tx_valid_q <= 1'b0;
            end
        end
    end

    // RQ17 - station list readable after job 201
    // RQ18 - group error in job status
    always_comb begin
        rd_val = BYTE_RESET;
        if (in_win(off, ADDR_OUT_BASE, N_OUT)) begin
            rd_val = out_img_q[OW'(off - ADDR_OUT_BASE)];
        end else if (in_win(off, ADDR_IN_BASE, N_IN)) begin
            rd_val = in_img_q[IW'(off - ADDR_IN_BASE)];
        end else if (in_win(off, ADDR_SLOT_OBJ, N_IN)) begin
            rd_val = slot_obj_q[IW'(off - ADDR_SLOT_OBJ)];
        end else if (in_win(off, ADDR_SLOT_STN, N_IN)) begin
            rd_val = slot_stn_q[IW'(off - ADDR_SLOT_STN)];
        end else if (in_win(off, ADDR_LIST_BASE, STATIONS)) begin
            rd_val = list_byte;
        end else if (off == ADDR_CTRL) begin
            rd_val = ctrl_q;
        end else if (off == ADDR_JOB) begin
            rd_val = job_q;
        end else if (off == ADDR_JOB_STAT) begin
            rd_val = {4'h0, js_q[JS_BADJOB_BIT], group_err, 1'b0, js_q[JS_DONE_BIT]};
        end else if (off == ADDR_OUT_OBJ) begin
            rd_val = out_obj_q;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_q <= BYTE_RESET;
        end else begin
            rd_data_q <= bus_req.rd ? rd_val : BYTE_RESET;
        end
    end

    assign rd_data      = rd_data_q;
    assign tx_entry     = tx_q;
    assign tx_valid     = tx_valid_q;
    assign tx_high_prio = tx_prio_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_free_rx_write: assert property (!sync_mode && hit[0] && !lost_hit[0]
        |=> in_img_q[0] == $past(rx_entry.data)) else $error("free rx not written"); // RQ1
    a_free_no_ovf: assert property (!sync_mode |-> ##1 !$rose(u_list.flag_q[rx_entry.station][ST_RXOVF_BIT]) || $past(sync_mode))
        else $error("overflow flagged in free mode"); // RQ2
    a_unchanged_quiet: assert property (cmp_go && !chg[0] && !tx_pend_q[0]
        |=> !tx_pend_q[0]) else $error("unchanged byte queued"); // RQ3
    a_sync_newest: assert property (sync_mode && hit[0] && !lost_hit[0]
        |=> pend_val_q[0] == $past(rx_entry.data) && pend_vld_q[0]) else $error("newest lost"); // RQ4
    a_sync_capture: assert property (sync_mode && !job_send && tx_pend_q == '0
        |=> tx_pend_q == '0) else $error("send outside checkpoint"); // RQ5
    a_changed_sent: assert property (cmp_go && chg[0] |=> tx_pend_q[0]
        && tx_val_q[0] == $past(eff[0])) else $error("changed byte not queued"); // RQ6
    a_sync_hold_in: assert property (sync_mode && !job_recv && !lost_hit[0]
        |=> $stable(in_img_q[0])) else $error("input moved between checkpoints"); // RQ9
    a_recv_commit: assert property (job_recv && pend_vld_q[0] && !lost_hit[0]
        |=> in_img_q[0] == $past(pend_val_q[0])) else $error("commit missed"); // RQ9
    a_rx_ovf_err: assert property (set_rxovf |-> ##2 group_err)
        else $error("rx overflow not grouped"); // RQ10
    a_stop_zero: assert property (cmp_go && !host_run && snap[0] != 8'h00
        |=> tx_pend_q[0] && tx_val_q[0] == 8'h00) else $error("stop zero not sent"); // RQ16
    a_fail_grouped: assert property (stn_lost |-> ##2 group_err)
        else $error("failure not grouped"); // RQ20
    a_fail_zero: assert property (lost_hit[0] |=> in_img_q[0] == 8'h00 && !pend_vld_q[0])
        else $error("failed inputs not cleared"); // RQ21
    a_tx_ovf_err: assert property (set_txovf |-> ##2 group_err)
        else $error("tx overflow not grouped"); // RQ19

    c_free_frame: cover property (!sync_mode && tx_valid_q && tx_ready && tx_q.last);
    c_sync_commit: cover property (job_recv && pend_vld_q != '0);
    c_station_lost: cover property (lost_hit != '0);
    c_tx_overflow: cover property (set_txovf);

endmodule

// ### hw/gpx_station_list.sv
/*
 * Station list: one status byte per remote station address.
 * Assumes pulses for each event; a set always wins over a clear.
 */
`timescale 1ns/1ps
module gpx_station_list
    import gpx_pkg::*;
(
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    // events
    input  wire logic                set_fail,
    input  wire logic [ST_IDX_W-1:0] fail_idx,
    input  wire logic                seen,
    input  wire logic [ST_IDX_W-1:0] seen_idx,
    input  wire logic                set_rxovf,
    input  wire logic [ST_IDX_W-1:0] rxovf_idx,
    input  wire logic                set_txovf,
    input  wire logic [ST_IDX_W-1:0] txovf_idx,
    input  wire logic                clr_ovf,
    // read side
    input  wire logic [ST_IDX_W-1:0] rd_idx,
    output logic      [7:0]          rd_byte,
    output logic                     any_err
);

    logic [STATIONS-1:0][ST_FLAG_W-1:0] flag_q;
    logic                               any_err_q;

    // RQ22 - one status byte per station
    for (genvar g = 0; g < STATIONS; g++) begin : g_stn
        always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
                flag_q[g] <= '0;
            end else begin
                if (seen && seen_idx == ST_IDX_W'(g)) begin
                    flag_q[g][ST_FAIL_BIT] <= 1'b0;
                end
                // RQ20 - record sender failure
                if (set_fail && fail_idx == ST_IDX_W'(g)) begin
                    flag_q[g][ST_FAIL_BIT] <= 1'b1;
                end
                if (clr_ovf) begin
                    flag_q[g][ST_RXOVF_BIT] <= 1'b0;
                    flag_q[g][ST_TXOVF_BIT] <= 1'b0;
                end
                if (set_rxovf && rxovf_idx == ST_IDX_W'(g)) begin
                    flag_q[g][ST_RXOVF_BIT] <= 1'b1;
                end
                if (set_txovf && txovf_idx == ST_IDX_W'(g)) begin
                    flag_q[g][ST_TXOVF_BIT] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            any_err_q <= 1'b0;
        end else begin
            any_err_q <= |flag_q;
        end
    end

    assign rd_byte = {(8 - ST_FLAG_W)'(0), flag_q[rd_idx]};
    assign any_err = any_err_q;

endmodule

// ### verif/gpx_bus_model.sv
/*
 * Bus layer model: takes change entries with random stalls.
 * Assumes the bench reads got and drives stall.
 */
`timescale 1ns/1ps
module gpx_bus_model
    import gpx_pkg::*;
(
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    // change frames
    input  wire tx_entry_type tx_entry,
    input  wire logic         tx_valid,
    output logic              tx_ready,
    // bench control
    input  wire logic         stall
);
    int           seed = 85;
    tx_entry_type got[$];

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_ready <= 1'b0;
        end else begin
            if (tx_valid && tx_ready) begin
                got.push_back(tx_entry);
            end
            tx_ready <= !stall && ($random(seed) & 1);
        end
    end
endmodule

// ### verif/gpx_exchange_tb.sv
/*
 * Self-checking bench for gpx_exchange with a behavioural model.
 * Assumes gpx_bus_model on the change frame output.
 */
`timescale 1ns/1ps
module gpx_exchange_tb
    import gpx_pkg::*;
;
    logic                clk_sys = 1'b0;
    logic                rst_b = 1'b0;
    bus_req_type         bus_req = '0;
    logic [7:0]          rd_data;
    tx_entry_type        tx_entry;
    logic                tx_valid;
    logic                tx_high_prio;
    logic                tx_ready;
    logic                stall = 1'b0;
    logic                rx_valid = 1'b0;
    rx_entry_type        rx_entry = '0;
    logic                stn_lost = 1'b0;
    logic [ST_IDX_W-1:0] stn_lost_idx = '0;
    int                  mismatches = 0;
    int                  samples_checked = 0;
    int                  seed = 85;
    int                  snap[16];
    int                  outv[16];
    int                  v;
    tx_entry_type        exp_q[$];

    always #5 clk_sys = ~clk_sys;

    gpx_exchange gpx_exchange_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
        .tx_entry(tx_entry), .tx_valid(tx_valid), .tx_high_prio(tx_high_prio),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_entry(rx_entry),
        .stn_lost(stn_lost), .stn_lost_idx(stn_lost_idx));

    gpx_bus_model gpx_bus_model_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .tx_entry(tx_entry),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .stall(stall));

    task automatic finish_test();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_tx(input tx_entry_type g, input tx_entry_type e);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk_sys);
        bus_req <= '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        access(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        access(1'b0, a, 8'h00);
        #1 chk8(rd_data, e);
    endtask

    task automatic put(input int i, input int d);
        wr(ADDR_OUT_BASE + 8'(i), 8'(d));
        outv[i] = d & 8'hff;
    endtask

    // frame completes once valid drops and every expected entry arrived
    task automatic drain();
        int n;
        n = 0;
        repeat (3) @(posedge clk_sys);
        while (n < 300 && (tx_valid !== 1'b0
               || gpx_bus_model_inst.got.size() < exp_q.size())) begin
            @(posedge clk_sys);
            n++;
        end
        #1 chk8(8'(gpx_bus_model_inst.got.size()), 8'(exp_q.size()));
        foreach (exp_q[k]) begin
            if (k < gpx_bus_model_inst.got.size()) begin
                chk_tx(gpx_bus_model_inst.got[k], exp_q[k]);
            end
        end
        exp_q.delete();
        gpx_bus_model_inst.got.delete();
    endtask

    // model of the new/old comparison at a send checkpoint
    task automatic send_point(input bit run);
        int c;
        for (int i = 0; i < 16; i++) begin
            c = run ? outv[i] : 0;
            if (c != snap[i]) begin
                exp_q.push_back('{obj: 8'h80 + 8'(i), data: 8'(c), last: 1'b0});
            end
            snap[i] = c;
        end
        if (exp_q.size() > 0) begin
            exp_q[$].last = 1'b1;
        end
        wr(ADDR_JOB, JOB_SEND);
        drain();
    endtask

    task automatic rx(input logic [7:0] o, input logic [7:0] d);
        @(posedge clk_sys);
        rx_valid <= 1'b1;
        rx_entry <= '{5'h03, o, d};
        @(posedge clk_sys);
        rx_valid <= 1'b0;
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        #1 chk8(8'(tx_high_prio), 8'h01);
        rd(ADDR_CTRL, CTRL_RESET);
        rd(ADDR_LIST_BASE + 8'h1f, 8'h00);
        wr(ADDR_OUT_OBJ, 8'h80);
        wr(ADDR_CTRL, 8'h03);
        put(2, $random(seed) | 1);
        put(5, $random(seed) | 1);
        drain();
        send_point(1'b1);
        v = outv[2];
        put(2, v ^ 8'hff);
        put(2, v);
        put(9, $random(seed) | 1);
        send_point(1'b1);
        stall <= 1'b1;
        put(1, 8'h11);
        wr(ADDR_JOB, JOB_SEND);
        put(1, 8'h22);
        wr(ADDR_JOB, JOB_SEND);
        rd(ADDR_LIST_BASE, 8'h00);
        put(1, 8'h33);
        wr(ADDR_JOB, JOB_SEND);
        rd(ADDR_LIST_BASE, 8'h04);
        rd(ADDR_JOB_STAT, 8'h05);
        stall <= 1'b0;
        snap[1] = 8'h33;
        exp_q.push_back('{8'h81, 8'h11, 1'b1});
        exp_q.push_back('{8'h81, 8'h33, 1'b1});
        drain();
        wr(ADDR_JOB, JOB_LIST);
        rd(ADDR_LIST_BASE, 8'h00);
        rd(ADDR_JOB_STAT, 8'h01);
        wr(ADDR_CTRL, 8'h01);
        send_point(1'b0);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_SLOT_OBJ, 8'h30);
        wr(ADDR_SLOT_STN, 8'h83);
        rx(8'h30, 8'h0a);
        rx(8'h30, 8'h0b);
        rx(8'h31, 8'hff);
        rd(ADDR_IN_BASE, 8'h0b);
        rd(ADDR_LIST_BASE + 8'h03, 8'h00);
        wr(ADDR_CTRL, 8'h01);
        rx(8'h30, 8'h05);
        rd(ADDR_IN_BASE, 8'h0b);
        rx(8'h30, 8'h06);
        wr(ADDR_JOB, JOB_RECV);
        rd(ADDR_IN_BASE, 8'h06);
        rd(ADDR_LIST_BASE + 8'h03, 8'h02);
        rd(ADDR_JOB_STAT, 8'h05);
        wr(ADDR_JOB, JOB_LIST);
        @(posedge clk_sys);
        stn_lost <= 1'b1;
        stn_lost_idx <= 5'h03;
        @(posedge clk_sys);
        stn_lost <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rd(ADDR_IN_BASE, 8'h00);
        rd(ADDR_LIST_BASE + 8'h03, 8'h01);
        rd(ADDR_JOB_STAT, 8'h05);
        wr(ADDR_JOB, 8'h01);
        rd(ADDR_JOB_STAT, 8'h0d);
        finish_test();
    end

    // far beyond the few hundred cycles the sequence needs
    initial begin
        #200000;
        mismatches++;
        finish_test();
    end
endmodule
